// ===== sim/data_paging_eeprom_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module data_paging_eeprom_ctrl_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1; // Held 16 cycles
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] prog_rdata = 8'h00; // Program memory model output
  logic [11:0] pa_q; // Captured program address
  logic req_ready, resp_valid, prog_rd, nv_busy_flag, row_error;
  logic [7:0] resp_data, shadow_window, shadow_bank;
  logic [11:0] prog_addr;
  logic err_seen = 1'b0; // Row error pulse caught
  int fail_count = 0;
  int checks_done = 0;
  // Busy length here; long enough to read the status mid-cycle
  localparam int SIM_PROG = 8;
  typedef struct packed {logic [7:0] win; logic [7:0] a; logic [11:0] pa;} row_t;
  // Window value, data address, program address it must reach
  row_t rows [4] = '{'{8'h28, 8'h59, 12'ha19}, '{8'h3f, 8'h7f, 12'hfff},
    '{8'he5, 8'h40, 12'h940}, '{8'h00, 8'h40, 12'h000}};
  paging_if bus();
  core_port i_core_port (.sys_clk(sys_clk), .reset(reset), .bus(bus), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_data(resp_data), .resp_valid(resp_valid), .shadow_window(shadow_window),
    .shadow_bank(shadow_bank));
  data_paging_eeprom_ctrl #(.PROG_CYCLES(SIM_PROG)) i_data_paging_eeprom_ctrl (.sys_clk(sys_clk),
    .reset(reset), .bus(bus), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_rdata(prog_rdata), .nv_busy_flag(nv_busy_flag), .row_error(row_error));
  paging_assertions #(.PROG_CYCLES(SIM_PROG)) i_paging_assertions (.sys_clk(sys_clk),
    .reset(reset),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .sel(bus.sel), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .nv_busy_flag(nv_busy_flag), .row_error(row_error));
  always #50 sys_clk = ~sys_clk;
  // Program memory pattern: low address byte XOR the high nibble doubled
  function automatic logic [7:0] pmem(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  // Program memory answers the cycle after the request
  always @(posedge sys_clk) begin
    pa_q = prog_addr;
    #1 prog_rdata = pmem(pa_q);
  end
  // Pulse is one cycle wide, so latch it
  always @(posedge sys_clk) if (row_error === 1'b1) err_seen = 1'b1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request, held across one sampling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
  endtask
  // Bounded wait for the answer
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    acc(1'b0, a, 8'h00);
    n = 0;
    while (resp_valid !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #2 n++;
    end
    // A missing answer would leave stale data that could still match
    if (resp_valid !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: no read answer", $time);
    end
    chk(resp_data, exp);
  endtask
  // Long enough to see a whole cycle finish
  task automatic busy_chk(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      #2 if (nv_busy_flag === 1'b1) seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #2000000 fail_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    chk({5'h00, req_ready, bus.rvalid, nv_busy_flag}, 8'h04);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'hc9, rows[i].win);
      rd_chk(rows[i].a, pmem(rows[i].pa));
      chk(shadow_window, rows[i].win);
    end
    $display("test window done");
    acc(1'b1, 8'hcb, 8'h08);
    acc(1'b1, 8'h00, 8'ha5);
    acc(1'b1, 8'h3f, 8'h5a);
    acc(1'b1, 8'hcb, 8'h10);
    acc(1'b1, 8'h00, 8'hc3);
    acc(1'b1, 8'hcb, 8'h08);
    rd_chk(8'h00, 8'ha5);
    rd_chk(8'h3f, 8'h5a);
    chk(shadow_bank, 8'h08);
    acc(1'b1, 8'hcb, 8'h10);
    rd_chk(8'h00, 8'hc3);
    $display("test ram pages done");
    acc(1'b1, 8'hcb, 8'h01);
    acc(1'b1, 8'hdf, 8'h00);
    acc(1'b1, 8'h05, 8'h11);
    busy_chk(1'b0);
    acc(1'b1, 8'hdf, 8'h01);
    acc(1'b1, 8'h19, 8'h77);
    busy_chk(1'b1);
    acc(1'b1, 8'h05, 8'h22);
    acc(1'b1, 8'hdf, 8'h40);
    rd_chk(8'hdf, 8'h02);
    busy_chk(1'b1);
    rd_chk(8'h05, 8'h22);
    rd_chk(8'h19, 8'h77);
    acc(1'b1, 8'hdf, 8'h41);
    acc(1'b1, 8'h05, 8'h33);
    busy_chk(1'b0);
    rd_chk(8'hdf, 8'h00);
    $display("test byte mode done");
    acc(1'b1, 8'hdf, 8'h05);
    acc(1'b1, 8'h18, 8'ha1);
    acc(1'b1, 8'h1a, 8'ha2);
    acc(1'b1, 8'h1b, 8'ha3);
    acc(1'b1, 8'h20, 8'hff);
    busy_chk(1'b0);
    chk({7'h00, err_seen}, 8'h01);
    acc(1'b1, 8'hdf, 8'h0d);
    busy_chk(1'b1);
    rd_chk(8'h18, 8'ha1);
    rd_chk(8'h1a, 8'ha2);
    rd_chk(8'h1b, 8'ha3);
    rd_chk(8'h19, 8'h77);
    acc(1'b1, 8'hdf, 8'h09);
    busy_chk(1'b0);
    acc(1'b1, 8'hdf, 8'h04);
    acc(1'b1, 8'hdf, 8'h0c);
    busy_chk(1'b0);
    $display("test row mode done");
    acc(1'b1, 8'hdf, 8'h01);
    acc(1'b1, 8'hcb, 8'h02);
    acc(1'b1, 8'h05, 8'h44);
    busy_chk(1'b1);
    rd_chk(8'h05, 8'h44);
    acc(1'b1, 8'hcb, 8'h01);
    rd_chk(8'h05, 8'h22);
    $display("test second page done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== sim/paging_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus and status checker
// ----------------------------------------
module paging_assertions #(
  parameter int PROG_CYCLES = 4 // Busy length
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic sel,
  input wire logic [11:0] prog_addr,
  input wire logic prog_rd,
  input wire logic nv_busy_flag,
  input wire logic row_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] busy_cnt_q; // Busy cycles so far
  // Counter avoids a long repetition
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= nv_busy_flag ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  property p_read_latency; rd |=> rvalid; endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");
  property p_rvalid_cause; rvalid |-> $past(rd); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
  property p_win_addr; (rd && addr[7:6] == 2'h1) |-> prog_rd && prog_addr[5:0] == addr[5:0];
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong");
  property p_win_only; prog_rd |-> rd && addr[7:6] == 2'h1; endproperty
  a_win_only: assert property (p_win_only) else $error("stray program read");
  property p_win_sel; prog_rd |=> rvalid && sel; endproperty
  a_win_sel: assert property (p_win_sel) else $error("window read unanswered");
  property p_win_load;
    (wr && addr == paging_pkg::ADDR_ROM_WINDOW_SELECT) |=> prog_addr[11:6] == $past(wdata[5:0]);
  endproperty
  a_win_load: assert property (p_win_load) else $error("window not loaded");
  property p_win_hold;
    !(wr && addr == paging_pkg::ADDR_ROM_WINDOW_SELECT) |=> $stable(prog_addr[11:6]);
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window changed");
  property p_ctl_read;
    (rd && addr == paging_pkg::ADDR_NV_CONTROL) |=> rdata[7:2] == 6'h00 && !rdata[0];
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read shows more");
  property p_busy_cause; $rose(nv_busy_flag) |-> $past(wr); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  property p_busy_len; $fell(nv_busy_flag) |-> busy_cnt_q == PROG_CYCLES + 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  // Row errors come from a paged write or read one cycle earlier
  property p_row_err;
    row_error |-> $past(wr || rd) && $past(addr[7:6]) == 2'h0;
  endproperty
  a_row_err: assert property (p_row_err) else $error("row error misplaced");
  c_window: cover property (prog_rd);
  c_prog: cover property ($fell(nv_busy_flag));
  c_row_err: cover property (row_error);
endmodule
`default_nettype wire

// ===== src/core_port.sv
`timescale 1ns/1ps
`default_nettype none
// Core-side end: turns user requests into data-space accesses.
// Write-only registers keep a RAM-style shadow here, written first.
module core_port (
  input wire logic sys_clk,
  input wire logic reset,
  paging_if.core bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic [7:0] resp_data,
  output logic resp_valid,
  output logic [7:0] shadow_window,
  output logic [7:0] shadow_bank
);
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] resp;
    logic resp_v;
    logic [7:0] sh_win;
    logic [7:0] sh_bank;
  } state_t;
  state_t s_q, s_d;
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.resp_v = bus.rvalid;
    if (bus.rvalid) begin
      s_d.resp = bus.rdata;
    end
    if (req_valid) begin
      s_d.addr = req_addr;
      s_d.wdata = req_wdata;
      s_d.wr = req_write;
      s_d.rd = !req_write;
      // Shadow updated with the write, never read back from device
      if (req_write && req_addr == paging_pkg::ADDR_ROM_WINDOW_SELECT) begin
        s_d.sh_win = req_wdata;
      end
      if (req_write && req_addr == paging_pkg::ADDR_DATA_BANK_SELECT) begin
        s_d.sh_bank = req_wdata;
      end
    end
  end
  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign req_ready = 1'b1;
  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;
  assign bus.wr = s_q.wr;
  assign bus.rd = s_q.rd;
  assign resp_data = s_q.resp;
  assign resp_valid = s_q.resp_v;
  assign shadow_window = s_q.sh_win;
  assign shadow_bank = s_q.sh_bank;
endmodule
`default_nettype wire

// ===== src/data_paging_eeprom_ctrl.sv
// Notes on behaviour
// - window uses low six bits only
// - program address is window above offset
// - window register write-only, undefined at reset; reset clears it to zero here
// - software shadows write-only registers in RAM
// - bank bits decode RAM and EEPROM pages
// - addresses 00h-3Fh reach selected page
// - software sets at most one bank bit
// - bank register write-only, kept, not cleared; reset clears it to zero here
// - EEPROM in 64-byte pages, plain accesses
// - EEPROM access needs page and standby clear
// - programming starts only with write enable
// - busy set while programming, control writes ignored
// - EEPROM read timed like RAM read
// - byte writes and eight-byte row writes
// - byte-mode writes reach EEPROM cells at cycle end, row-mode writes go to row latches
// - software keeps control bits 4,5 zero
// - row latched at first write in row mode
// - row mode clears latches, programs written bytes
// - row mode cleared at cycle end
// - start settable only with enable and row mode
// - software avoids reads during row mode
// - row shares address bits 7-3
// - start bit cleared at procedure end
`timescale 1ns/1ps
`default_nettype none
module data_paging_eeprom_ctrl #(
  parameter int PROG_CYCLES = paging_pkg::PROG_CYCLES // Busy length
) (
  input wire logic sys_clk,
  input wire logic reset,
  paging_if.device bus,
  output logic [11:0] prog_addr, // Program memory address
  output logic prog_rd, // Program memory read strobe
  input wire logic [7:0] prog_rdata, // Program memory data
  output logic nv_busy_flag, // Programming in progress
  output logic row_error // Access outside latched row
);
  localparam int NV_BYTES = 2 * paging_pkg::PAGE_BYTES;
  localparam int RAM_BYTES = 2 * paging_pkg::PAGE_BYTES;
  localparam logic [paging_pkg::CNT_W-1:0] PROG_LEN = PROG_CYCLES[paging_pkg::CNT_W-1:0];
  // ------------------------------------------------------------
  // Arrays: EEPROM cells and paged RAM; row writes wait in row_data
  // ------------------------------------------------------------
  logic [7:0] nv_mem [NV_BYTES];
  logic [7:0] ram_mem [RAM_BYTES];
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BYTE = 2'b01,
    ST_ROW = 2'b10
  } prog_t;
  typedef struct packed {
    logic [7:0] win; // Window register, zero from reset until written
    logic [7:0] bank; // Bank register
    logic standby;
    logic wr_en;
    logic row_mode;
    logic row_start;
    prog_t st;
    logic [paging_pkg::CNT_W-1:0] cnt;
    logic row_latched;
    logic [3:0] row; // Latched row: page bit and offset bits 5-3
    logic [7:0] row_used; // Row bytes written since row mode
    logic [63:0] row_data; // Volatile row latches
    logic [6:0] byte_addr; // Pending byte-mode address
    logic [7:0] byte_data;
    logic rvalid;
    logic [7:0] rdata;
    logic sel;
    logic win_rd; // Window read pending
    logic err;
  } state_t;
  state_t s_q, s_d;
  logic in_page, in_win, nv_sel, ram_sel, nv_ok;
  logic [6:0] nv_idx, ram_idx;
  logic prog_done;
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    in_page = bus.addr[7:6] == paging_pkg::REGION_PAGED;
    in_win = bus.addr[7:6] == paging_pkg::REGION_WINDOW;
    nv_sel = s_q.bank[paging_pkg::BANK_NV0] | s_q.bank[paging_pkg::BANK_NV1];
    ram_sel = s_q.bank[paging_pkg::BANK_RAM1] | s_q.bank[paging_pkg::BANK_RAM2];
    nv_ok = nv_sel && !s_q.standby && s_q.st == ST_IDLE;
    // Several bits set would hit two pages; low bit wins here
    nv_idx = {s_q.bank[paging_pkg::BANK_NV1] & ~s_q.bank[paging_pkg::BANK_NV0],
      bus.addr[5:0]};
    ram_idx = {s_q.bank[paging_pkg::BANK_RAM2] & ~s_q.bank[paging_pkg::BANK_RAM1],
      bus.addr[5:0]};
    prog_done = s_q.st != ST_IDLE && s_q.cnt == PROG_LEN;
  end
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.sel = 1'b0;
    s_d.win_rd = 1'b0;
    s_d.err = 1'b0;
    if (s_q.st != ST_IDLE) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (prog_done) begin
      s_d.st = ST_IDLE;
      s_d.cnt = '0;
      if (s_q.st == ST_ROW) begin
        s_d.row_mode = 1'b0;
        s_d.row_start = 1'b0;
        s_d.row_latched = 1'b0;
      end
    end
    if (bus.wr) begin
      if (bus.addr == paging_pkg::ADDR_ROM_WINDOW_SELECT) begin
        s_d.win = bus.wdata;
      end
      if (bus.addr == paging_pkg::ADDR_DATA_BANK_SELECT) begin
        s_d.bank = bus.wdata; // Only written here, so kept
      end
      // Control writes ignored while busy
      if (bus.addr == paging_pkg::ADDR_NV_CONTROL && s_q.st == ST_IDLE) begin
        s_d.standby = bus.wdata[paging_pkg::CTL_STANDBY];
        s_d.wr_en = bus.wdata[paging_pkg::CTL_WRITE_ENABLE];
        s_d.row_mode = bus.wdata[paging_pkg::CTL_ROW_MODE];
        if (bus.wdata[paging_pkg::CTL_ROW_MODE] && !s_q.row_mode) begin
          s_d.row_used = '0;
          s_d.row_data = '0;
          s_d.row_latched = 1'b0;
        end
        if (!bus.wdata[paging_pkg::CTL_ROW_MODE]) begin
          s_d.row_latched = 1'b0; // Abandon row, cells unchanged
        end
        // Start takes only with enable and row mode
        if (bus.wdata[paging_pkg::CTL_ROW_START] && bus.wdata[paging_pkg::CTL_WRITE_ENABLE]
            && bus.wdata[paging_pkg::CTL_ROW_MODE] && s_q.row_mode) begin
          s_d.row_start = 1'b1;
          s_d.st = ST_ROW;
          s_d.cnt = '0;
        end
      end
      if (in_page && ram_sel) begin
        s_d.rdata = s_q.rdata;
      end
      if (in_page && nv_ok && s_q.wr_en) begin
        if (s_q.row_mode) begin
          if (!s_q.row_latched || s_q.row == nv_idx[6:paging_pkg::ROW_SEL_W]) begin
            s_d.row_latched = 1'b1;
            s_d.row = nv_idx[6:paging_pkg::ROW_SEL_W];
            s_d.row_used[bus.addr[2:0]] = 1'b1;
            s_d.row_data[bus.addr[2:0]*8 +: 8] = bus.wdata;
          end else begin
            s_d.err = 1'b1;
          end
        end else begin
          s_d.st = ST_BYTE;
          s_d.cnt = '0;
          s_d.byte_addr = nv_idx;
          s_d.byte_data = bus.wdata;
        end
      end
    end
    if (bus.rd) begin
      s_d.rvalid = 1'b1;
      if (bus.addr == paging_pkg::ADDR_NV_CONTROL) begin
        s_d.sel = 1'b1;
        s_d.rdata = 8'h00;
        s_d.rdata[paging_pkg::CTL_BUSY] = s_q.st != ST_IDLE;
      end else if (in_win) begin
        s_d.sel = 1'b1;
        s_d.win_rd = 1'b1;
      end else if (in_page && nv_ok) begin
        s_d.sel = 1'b1;
        s_d.rdata = nv_mem[nv_idx]; // Same one-cycle latency as RAM
        if (s_q.row_latched && s_q.row != nv_idx[6:paging_pkg::ROW_SEL_W]) begin
          s_d.err = 1'b1;
        end
      end else if (in_page && ram_sel) begin
        s_d.sel = 1'b1;
        s_d.rdata = ram_mem[ram_idx];
      end
    end
  end
  // ------------------------------------------------------------
  // State register; reset clears window and bank to zero
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // ------------------------------------------------------------
  // Array writes: RAM page, byte cycle end, row cycle end
  // ------------------------------------------------------------
  logic [paging_pkg::ROW_BYTES-1:0] row_we; // Per-byte cell write at row cycle end
  genvar g;
  generate
    for (g = 0; g < paging_pkg::ROW_BYTES; g++) begin : g_row
      // Only bytes loaded since row mode was enabled
      assign row_we[g] = prog_done && s_q.st == ST_ROW && s_q.row_used[g];
    end
  endgenerate
  // One process owns the cells, so the array has a single writer
  always_ff @(posedge sys_clk) begin
    if (bus.wr && in_page && ram_sel) begin
      ram_mem[ram_idx] <= bus.wdata;
    end
    if (prog_done && s_q.st == ST_BYTE) begin
      nv_mem[s_q.byte_addr] <= s_q.byte_data;
    end
    for (int b = 0; b < paging_pkg::ROW_BYTES; b++) begin
      if (row_we[b]) begin
        nv_mem[{s_q.row, 3'(b)}] <= s_q.row_data[b*8 +: 8];
      end
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prog_addr = {s_q.win[paging_pkg::WINDOW_W-1:0], bus.addr[5:0]};
  assign prog_rd = bus.rd && in_win;
  assign bus.rdata = s_q.win_rd ? prog_rdata : s_q.rdata;
  assign bus.rvalid = s_q.rvalid;
  assign bus.sel = s_q.sel;
  assign nv_busy_flag = s_q.st != ST_IDLE;
  assign row_error = s_q.err;
endmodule
`default_nettype wire

// ===== src/paging_if.sv
`timescale 1ns/1ps
`default_nettype none
// Data-space bus between the core and the paging block
interface paging_if;
  logic [7:0] addr; // Data address
  logic [7:0] wdata; // Write data
  logic wr; // Write strobe, one cycle
  logic rd; // Read strobe, one cycle
  logic [7:0] rdata; // Read data, valid cycle after rd
  logic rvalid; // Marks rdata
  logic sel; // Block owns the read answer
  modport device (input addr, input wdata, input wr, input rd,
    output rdata, output rvalid, output sel);
  modport core (output addr, output wdata, output wr, output rd,
    input rdata, input rvalid, input sel);
endinterface
`default_nettype wire

// ===== src/paging_pkg.sv
package paging_pkg;
  // ------------------------------------------------------------
  // Register addresses in data space
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_ROM_WINDOW_SELECT = 8'hc9; // Write only
  localparam logic [7:0] ADDR_DATA_BANK_SELECT = 8'hcb; // Write only
  localparam logic [7:0] ADDR_NV_CONTROL = 8'hdf; // Control and busy status
  // ------------------------------------------------------------
  // Address regions
  // ------------------------------------------------------------
  localparam logic [1:0] REGION_PAGED = 2'h0; // 00h-3Fh
  localparam logic [1:0] REGION_WINDOW = 2'h1; // 40h-7Fh
  localparam int OFFSET_W = 6; // Offset bits inside a 64-byte page
  localparam int WINDOW_W = 6; // Used window register bits
  localparam int PROG_ADDR_W = 12; // Program memory address width
  localparam int PAGE_BYTES = 64; // Bytes per page
  localparam int ROW_BYTES = 8; // Bytes per parallel row
  localparam int ROW_SEL_W = 3; // Byte select within a row
  // ------------------------------------------------------------
  // Bank register bit positions
  // ------------------------------------------------------------
  localparam int BANK_NV0 = 0;
  localparam int BANK_NV1 = 1;
  localparam int BANK_RAM1 = 3;
  localparam int BANK_RAM2 = 4;
  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int CTL_WRITE_ENABLE = 0;
  localparam int CTL_BUSY = 1;
  localparam int CTL_ROW_MODE = 2;
  localparam int CTL_ROW_START = 3;
  localparam int CTL_STANDBY = 6;
  localparam logic [7:0] CTL_RESET = 8'h00; // Control reset value
  // ------------------------------------------------------------
  // Programming time in core cycles
  // ------------------------------------------------------------
  localparam int PROG_CYCLES = 16; // Default busy length
  localparam int CNT_W = 16; // Busy counter width
endpackage
